// [hw/cfas_top.sv]
// Operation
// - active mode 00 accumulates active power signed
// - active mode 11 accumulates active magnitudes
// - reactive field used for types 001/100
// - mode 10 flips reactive with negative active
// - sign sampled at threshold hit, changes detected
// - sign-change flag set at next falling pulse
// - sum sign bits updated with flag set
// - masked sign-change flags pull first pin low
// - write one clears flag, releases first pin
// - no-load when both magnitudes at or under thresholds
// - negative thresholds disable active/reactive no-load
// - thresholds read zero-padded, sign-extended to 28
// - no-load transitions set flag and state bits
// - masked no-load flag pulls second pin low
// - apparent no-load when magnitude at or under threshold
// - negative apparent threshold disables detection
// - apparent transitions set flag and state bits
// - masked apparent flag pulls second pin low
// - write one clears no-load flag, releases pin
`timescale 1ns/1ps
module cfas_top
  import cfas_pkg::*;
(
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // per-phase powers from the signal processor
  input  wire logic                    sample_valid,
  input  wire logic signed [PWR_W-1:0] act_pwr_a,
  input  wire logic signed [PWR_W-1:0] act_pwr_b,
  input  wire logic signed [PWR_W-1:0] act_pwr_c,
  input  wire logic signed [PWR_W-1:0] react_pwr_a,
  input  wire logic signed [PWR_W-1:0] react_pwr_b,
  input  wire logic signed [PWR_W-1:0] react_pwr_c,
  input  wire logic signed [PWR_W-1:0] app_pwr_a,
  input  wire logic signed [PWR_W-1:0] app_pwr_b,
  input  wire logic signed [PWR_W-1:0] app_pwr_c,
  // output path type selections
  input  wire logic [2:0]              path1_type_select,
  input  wire logic [2:0]              path2_type_select,
  input  wire logic [2:0]              path3_type_select,
  // pulse converter feedback per path
  input  wire logic                    path1_thr_hit,
  input  wire logic                    path2_thr_hit,
  input  wire logic                    path3_thr_hit,
  input  wire logic                    path1_acc_neg,
  input  wire logic                    path2_acc_neg,
  input  wire logic                    path3_acc_neg,
  input  wire logic                    path1_pulse_fall,
  input  wire logic                    path2_pulse_fall,
  input  wire logic                    path3_pulse_fall,
  // conditioned power sums to the pulse converter
  output logic signed [SUM_W-1:0]      path1_power_sum,
  output logic signed [SUM_W-1:0]      path2_power_sum,
  output logic signed [SUM_W-1:0]      path3_power_sum,
  output logic                         power_sum_valid,
  // interrupt pins
  output logic                         first_interrupt_pin_n,
  output logic                         second_interrupt_pin_n
);

  // sign-extend a threshold to the datapath width
  function automatic logic signed [PWR_W-1:0] sext_thr(input logic [THR_W-1:0] t);
    sext_thr = {{(PWR_W-THR_W){t[THR_W-1]}}, t};
  endfunction

  // magnitude with one guard bit so the most negative value stays exact
  function automatic logic signed [PWR_W:0] mag(input logic signed [PWR_W-1:0] v);
    logic signed [PWR_W:0] w;
    w = {v[PWR_W-1], v};
    mag = v[PWR_W-1] ? -w : w;
  endfunction

  // one phase's contribution to a path
  function automatic logic signed [PWR_W:0] contrib(
    input logic [2:0]              sel,
    input logic [1:0]              amode,
    input logic [1:0]              rmode,
    input logic signed [PWR_W-1:0] p,
    input logic signed [PWR_W-1:0] q,
    input logic signed [PWR_W-1:0] s,
    input logic                    nl_ar,
    input logic                    nl_app
  );
    logic signed [PWR_W:0] pw;
    logic signed [PWR_W:0] qw;
    pw = {p[PWR_W-1], p};
    qw = {q[PWR_W-1], q};
    contrib = '0;
    case (sel)
      SEL_ACTIVE:
        if (!nl_ar)
          contrib = (amode == ACT_MODE_ABSOLUTE) ? mag(p) : pw;
      SEL_REACTIVE, SEL_REACTIVE2:
        if (!nl_ar)
          contrib = (rmode == REACT_MODE_SIGNADJ && p[PWR_W-1]) ? -qw : qw;
      SEL_APPARENT:
        if (!nl_app)
          contrib = {s[PWR_W-1], s};
      default:
        contrib = '0;
    endcase
  endfunction

  // registers
  logic [7:0]       accum_mode_q;
  logic [31:0]      mask_first_q;
  logic [31:0]      mask_second_q;
  logic [THR_W-1:0] act_thr_q;
  logic [THR_W-1:0] react_thr_q;
  logic [THR_W-1:0] app_thr_q;
  logic [2:0]       sign_change_q;
  logic [2:0]       sum_sign_q;
  logic [2:0]       last_sign_q;
  logic [2:0]       sign_pend_q;
  logic             ar_flag_q;
  logic             app_flag_q;
  logic [2:0]       ar_state_q;
  logic [2:0]       app_state_q;

  // packed views of the per-phase and per-path inputs
  logic signed [PWR_W-1:0] p_ph [3];
  logic signed [PWR_W-1:0] q_ph [3];
  logic signed [PWR_W-1:0] s_ph [3];
  logic [2:0]              sel_p [3];
  logic [2:0]              thr_hit;
  logic [2:0]              acc_neg;
  logic [2:0]              pfall;
  assign p_ph[0]  = act_pwr_a;
  assign p_ph[1]  = act_pwr_b;
  assign p_ph[2]  = act_pwr_c;
  assign q_ph[0]  = react_pwr_a;
  assign q_ph[1]  = react_pwr_b;
  assign q_ph[2]  = react_pwr_c;
  assign s_ph[0]  = app_pwr_a;
  assign s_ph[1]  = app_pwr_b;
  assign s_ph[2]  = app_pwr_c;
  assign sel_p[0] = path1_type_select;
  assign sel_p[1] = path2_type_select;
  assign sel_p[2] = path3_type_select;
  assign thr_hit  = {path3_thr_hit, path2_thr_hit, path1_thr_hit};
  assign acc_neg  = {path3_acc_neg, path2_acc_neg, path1_acc_neg};
  assign pfall    = {path3_pulse_fall, path2_pulse_fall, path1_pulse_fall};

  // apb decode
  logic acc;
  logic wr_fire;
  assign acc     = psel & penable;
  assign wr_fire = acc & pready & pwrite;

  // status register views
  logic [31:0] status_first;
  logic [31:0] status_second;
  logic [15:0] sign_reg;
  logic [15:0] nl_reg;
  always_comb
  begin
    status_first = '0;
    status_first[BIT_PATH1_SIGN_CHANGE] = sign_change_q[0];
    status_first[BIT_PATH2_SIGN_CHANGE] = sign_change_q[1];
    status_first[BIT_PATH3_SIGN_CHANGE] = sign_change_q[2];
    status_second = '0;
    status_second[BIT_ACT_REACT_NOLOAD] = ar_flag_q;
    status_second[BIT_APPARENT_NOLOAD]  = app_flag_q;
    sign_reg = '0;
    sign_reg[BIT_PATH1_SUM_SIGN] = sum_sign_q[0];
    sign_reg[BIT_PATH2_SUM_SIGN] = sum_sign_q[1];
    sign_reg[BIT_PATH3_SUM_SIGN] = sum_sign_q[2];
    nl_reg = '0;
    nl_reg[ACT_REACT_STATE_LSB +: 3] = ar_state_q;
    nl_reg[APPARENT_STATE_LSB +: 3]  = app_state_q;
  end

  // read mux
  logic [31:0] rd_d;
  logic        err_d;
  always_comb
  begin
    rd_d  = '0;
    err_d = 1'b0;
    case (paddr)
      OFS_ACCUM_MODE_CONFIG:  rd_d = {24'h00_0000, accum_mode_q};
      OFS_OUTPUT_SUM_SIGN:    rd_d = {16'h0000, sign_reg};
      OFS_INT_STATUS_FIRST:   rd_d = status_first;
      OFS_INT_MASK_FIRST:     rd_d = mask_first_q;
      OFS_ACTIVE_NL_THR:      rd_d = {4'h0, sext_thr(act_thr_q)};
      OFS_REACTIVE_NL_THR:    rd_d = {4'h0, sext_thr(react_thr_q)};
      OFS_INT_STATUS_SECOND:  rd_d = status_second;
      OFS_NOLOAD_PHASE_STATE: rd_d = {16'h0000, nl_reg};
      OFS_INT_MASK_SECOND:    rd_d = mask_second_q;
      OFS_APPARENT_NL_THR:    rd_d = {4'h0, sext_thr(app_thr_q)};
      default:                err_d = 1'b1;
    endcase
  end

  // apb answer, one wait cycle in the access phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= acc & ~pready;
      pslverr <= acc & ~pready & err_d;
      if (acc & ~pready)
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
    end
  end

  // software-written configuration
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      accum_mode_q  <= RST_ACCUM_MODE;
      mask_first_q  <= RST_MASK;
      mask_second_q <= RST_MASK;
      act_thr_q     <= RST_NL_THR;
      react_thr_q   <= RST_NL_THR;
      app_thr_q     <= RST_NL_THR;
    end
    else if (wr_fire)
    begin
      case (paddr)
        OFS_ACCUM_MODE_CONFIG: accum_mode_q  <= pwdata[7:0];
        OFS_INT_MASK_FIRST:    mask_first_q  <= pwdata;
        OFS_INT_MASK_SECOND:   mask_second_q <= pwdata;
        OFS_ACTIVE_NL_THR:     act_thr_q     <= pwdata[THR_W-1:0];
        OFS_REACTIVE_NL_THR:   react_thr_q   <= pwdata[THR_W-1:0];
        OFS_APPARENT_NL_THR:   app_thr_q     <= pwdata[THR_W-1:0];
        default:               ;
      endcase
    end
  end

  // no-load comparisons per phase, negative thresholds never match
  logic [2:0] ar_nl_now;
  logic [2:0] app_nl_now;
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      ar_nl_now[i] = !act_thr_q[THR_W-1] && !react_thr_q[THR_W-1]
                     && (mag(p_ph[i]) <= {1'b0, sext_thr(act_thr_q)})
                     && (mag(q_ph[i]) <= {1'b0, sext_thr(react_thr_q)});
      app_nl_now[i] = !app_thr_q[THR_W-1]
                      && (mag(s_ph[i]) <= {1'b0, sext_thr(app_thr_q)});
    end
  end

  // no-load state, updated on each sample
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ar_state_q  <= 3'h0;
      app_state_q <= 3'h0;
    end
    else if (sample_valid)
    begin
      ar_state_q  <= ar_nl_now;
      app_state_q <= app_nl_now;
    end
  end

  // no-load flags, transitions set, write-one clears, set wins
  logic ar_set;
  logic app_set;
  logic clr_second;
  assign ar_set     = sample_valid && (ar_nl_now != ar_state_q);
  assign app_set    = sample_valid && (app_nl_now != app_state_q);
  assign clr_second = wr_fire && (paddr == OFS_INT_STATUS_SECOND);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ar_flag_q  <= 1'b0;
      app_flag_q <= 1'b0;
    end
    else
    begin
      if (ar_set)
        ar_flag_q <= 1'b1;
      else if (clr_second && pwdata[BIT_ACT_REACT_NOLOAD])
        ar_flag_q <= 1'b0;
      if (app_set)
        app_flag_q <= 1'b1;
      else if (clr_second && pwdata[BIT_APPARENT_NOLOAD])
        app_flag_q <= 1'b0;
    end
  end

  // sign tracking at threshold hits, pending until falling pulse
  logic [2:0] sign_chg;
  assign sign_chg = thr_hit & (acc_neg ^ last_sign_q);
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      last_sign_q <= 3'h0;
      sign_pend_q <= 3'h0;
      sum_sign_q  <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (thr_hit[i])
          last_sign_q[i] <= acc_neg[i];
        if (sign_chg[i])
          sign_pend_q[i] <= 1'b1;
        else if (pfall[i])
          sign_pend_q[i] <= 1'b0;
        if (pfall[i] && sign_pend_q[i])
          sum_sign_q[i] <= last_sign_q[i];
      end
    end
  end

  // sign-change flags, set at falling pulse, write-one clears, set wins
  logic [2:0] clr_first;
  assign clr_first = (wr_fire && (paddr == OFS_INT_STATUS_FIRST))
                     ? {pwdata[BIT_PATH3_SIGN_CHANGE], pwdata[BIT_PATH2_SIGN_CHANGE],
                        pwdata[BIT_PATH1_SIGN_CHANGE]}
                     : 3'h0;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sign_change_q <= 3'h0;
    else
      sign_change_q <= (pfall & sign_pend_q) | (sign_change_q & ~clr_first);
  end

  // interrupt pins, active low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      first_interrupt_pin_n  <= 1'b1;
      second_interrupt_pin_n <= 1'b1;
    end
    else
    begin
      first_interrupt_pin_n  <= ~|(status_first & mask_first_q);
      second_interrupt_pin_n <= ~|(status_second & mask_second_q);
    end
  end

  // conditioned path sums toward the pulse converter
  logic signed [SUM_W-1:0] sum_d [3];
  always_comb
  begin
    for (int j = 0; j < 3; j++)
    begin
      sum_d[j] = '0;
      for (int i = 0; i < 3; i++)
        sum_d[j] = sum_d[j] + SUM_W'(contrib(sel_p[j],
                     accum_mode_q[ACT_FIELD_LSB +: 2], accum_mode_q[REACT_FIELD_LSB +: 2],
                     p_ph[i], q_ph[i], s_ph[i], ar_nl_now[i], app_nl_now[i]));
    end
  end

  // path sums registered on each sample
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      path1_power_sum <= '0;
      path2_power_sum <= '0;
      path3_power_sum <= '0;
      power_sum_valid <= 1'b0;
    end
    else
    begin
      power_sum_valid <= sample_valid;
      if (sample_valid)
      begin
        path1_power_sum <= sum_d[0];
        path2_power_sum <= sum_d[1];
        path3_power_sum <= sum_d[2];
      end
    end
  end

endmodule

// [hw/cfas_pkg.sv]
package cfas_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_ACCUM_MODE_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_SUM_SIGN    = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS_FIRST   = 8'h08;
  localparam logic [7:0] OFS_INT_MASK_FIRST     = 8'h0C;
  localparam logic [7:0] OFS_ACTIVE_NL_THR      = 8'h10;
  localparam logic [7:0] OFS_REACTIVE_NL_THR    = 8'h14;
  localparam logic [7:0] OFS_INT_STATUS_SECOND  = 8'h18;
  localparam logic [7:0] OFS_NOLOAD_PHASE_STATE = 8'h1C;
  localparam logic [7:0] OFS_INT_MASK_SECOND    = 8'h20;
  localparam logic [7:0] OFS_APPARENT_NL_THR    = 8'h24;

  // reset values
  localparam logic [7:0]  RST_ACCUM_MODE = 8'h00;
  localparam logic [31:0] RST_MASK       = 32'h0000_0000;
  localparam logic [23:0] RST_NL_THR     = 24'h00_0000;

  // accumulation config fields
  localparam int ACT_FIELD_LSB   = 0;
  localparam int REACT_FIELD_LSB = 2;
  localparam logic [1:0] ACT_MODE_SIGNED    = 2'h0;
  localparam logic [1:0] ACT_MODE_ABSOLUTE  = 2'h3;
  localparam logic [1:0] REACT_MODE_SIGNED  = 2'h0;
  localparam logic [1:0] REACT_MODE_SIGNADJ = 2'h2;

  // output path type selections
  localparam logic [2:0] SEL_ACTIVE    = 3'h0;
  localparam logic [2:0] SEL_REACTIVE  = 3'h1;
  localparam logic [2:0] SEL_APPARENT  = 3'h2;
  localparam logic [2:0] SEL_REACTIVE2 = 3'h4;

  // first status / mask bits, path 1..3
  localparam int BIT_PATH1_SIGN_CHANGE = 9;
  localparam int BIT_PATH2_SIGN_CHANGE = 13;
  localparam int BIT_PATH3_SIGN_CHANGE = 18;
  // sum sign bits, path 1..3
  localparam int BIT_PATH1_SUM_SIGN = 3;
  localparam int BIT_PATH2_SUM_SIGN = 7;
  localparam int BIT_PATH3_SUM_SIGN = 8;
  // second status / mask bits
  localparam int BIT_ACT_REACT_NOLOAD = 0;
  localparam int BIT_APPARENT_NOLOAD  = 2;
  // no-load phase state field positions
  localparam int ACT_REACT_STATE_LSB = 0;
  localparam int APPARENT_STATE_LSB  = 6;

  // datapath widths
  localparam int PWR_W = 28;
  localparam int THR_W = 24;
  localparam int SUM_W = 31;

endpackage

// [tb/cfas_chk_sva.sv]
`timescale 1ns/1ps
module cfas_chk
  import cfas_pkg::*;
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // apb
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic                    pready,
  // datapath
  input wire logic                    sample_valid,
  input wire logic                    power_sum_valid,
  input wire logic signed [SUM_W-1:0] path1_power_sum,
  input wire logic                    path1_pulse_fall,
  input wire logic                    path2_pulse_fall,
  input wire logic                    path3_pulse_fall,
  // pins
  input wire logic                    first_interrupt_pin_n,
  input wire logic                    second_interrupt_pin_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // completed writes that may move a pin
  wire wr   = psel && penable && pready && pwrite;
  wire wr1  = wr && (paddr == OFS_INT_STATUS_FIRST || paddr == OFS_INT_MASK_FIRST);
  wire wr2  = wr && (paddr == OFS_INT_STATUS_SECOND || paddr == OFS_INT_MASK_SECOND);
  wire fall = path1_pulse_fall || path2_pulse_fall || path3_pulse_fall;
  // apb phases
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  AST_APB_WAIT: assert property (s_setup |=> s_wait ##1 pready)
    else $error("apb answer not after one wait cycle");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_SUM_VALID: assert property (sample_valid |=> power_sum_valid)
    else $error("no sum after sample");
  AST_SUM_HOLD: assert property (!sample_valid |=> !power_sum_valid && $stable(path1_power_sum))
    else $error("sum moved without sample");
  AST_PIN1_FALL: assert property ($fell(first_interrupt_pin_n) |-> $past(fall, 2) || $past(wr1, 2) || $past(wr1, 3))
    else $error("first pin fell without cause");
  AST_PIN1_RISE: assert property ($rose(first_interrupt_pin_n) |-> $past(wr1, 2) || $past(wr1, 3))
    else $error("first pin rose without write");
  AST_PIN2_FALL: assert property ($fell(second_interrupt_pin_n) |-> $past(sample_valid, 2) || $past(wr2, 2) || $past(wr2, 3))
    else $error("second pin fell without cause");
  AST_PIN2_RISE: assert property ($rose(second_interrupt_pin_n) |-> $past(wr2, 2) || $past(wr2, 3))
    else $error("second pin rose without write");
endmodule
bind cfas_top cfas_chk u_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pready,
  .sample_valid, .power_sum_valid, .path1_power_sum, .path1_pulse_fall, .path2_pulse_fall,
  .path3_pulse_fall, .first_interrupt_pin_n, .second_interrupt_pin_n);

// [tb/cfas_host.sv]
`timescale 1ns/1ps
module cfas_host
  import cfas_pkg::*;
(
  // clock
  input  wire logic        clk,
  // apb request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic err;
  // bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // one transfer, request held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // status read, companion read, then status written back
  task automatic service(input logic [7:0] sa, input logic [7:0] ca,
                         output logic [31:0] s, output logic [31:0] c);
    logic [31:0] r;
    xfer(1'b0, sa, 32'h0, s);
    xfer(1'b0, ca, 32'h0, c);
    xfer(1'b1, sa, s, r);
  endtask
endmodule

// [tb/cf_accum_sign_noload_bench.sv]
`timescale 1ns/1ps
module cf_accum_sign_noload_bench
  import cfas_pkg::*;
;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    psel, penable, pwrite, pready, pslverr;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, rd, st, ph;
  logic                    sample_valid = 1'b0;
  logic                    power_sum_valid, first_interrupt_pin_n, second_interrupt_pin_n;
  logic signed [PWR_W-1:0] ap [3], rp [3], sp [3];
  logic [2:0]              path1_type_select = SEL_ACTIVE;
  logic [2:0]              path2_type_select = SEL_REACTIVE;
  logic [2:0]              path3_type_select = SEL_REACTIVE2;
  logic [2:0]              hit = '0, neg = '0, fall = '0;
  logic signed [SUM_W-1:0] path1_power_sum, path2_power_sum, path3_power_sum;
  int                      n_fail = 0, check_count = 0, cyc = 0;

  cfas_host host (.*);
  cfas_top uut (
    .*,
    .act_pwr_a(ap[0]), .act_pwr_b(ap[1]), .act_pwr_c(ap[2]),
    .react_pwr_a(rp[0]), .react_pwr_b(rp[1]), .react_pwr_c(rp[2]),
    .app_pwr_a(sp[0]), .app_pwr_b(sp[1]), .app_pwr_c(sp[2]),
    .path1_thr_hit(hit[0]), .path2_thr_hit(hit[1]), .path3_thr_hit(hit[2]),
    .path1_acc_neg(neg[0]), .path2_acc_neg(neg[1]), .path3_acc_neg(neg[2]),
    .path1_pulse_fall(fall[0]), .path2_pulse_fall(fall[1]), .path3_pulse_fall(fall[2])
  );

  // clock and watchdog
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one power sample, then settle
  task automatic samp(input int p [3], input int q [3], input int s [3]);
    @(posedge clk);
    foreach (ap[i])
    begin
      ap[i] <= PWR_W'(p[i]);
      rp[i] <= PWR_W'(q[i]);
      sp[i] <= PWR_W'(s[i]);
    end
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // threshold hit with a sign, then a falling pulse edge
  task automatic pulse(input int i, input logic n);
    @(posedge clk);
    hit[i] <= 1'b1;
    neg[i] <= n;
    @(posedge clk);
    hit[i] <= 1'b0;
    fall[i] <= 1'b1;
    @(posedge clk);
    fall[i] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_regs();
    logic [7:0] a [10] = '{OFS_ACCUM_MODE_CONFIG, OFS_OUTPUT_SUM_SIGN, OFS_INT_STATUS_FIRST,
      OFS_INT_MASK_FIRST, OFS_ACTIVE_NL_THR, OFS_REACTIVE_NL_THR, OFS_INT_STATUS_SECOND,
      OFS_NOLOAD_PHASE_STATE, OFS_INT_MASK_SECOND, OFS_APPARENT_NL_THR};
    foreach (a[i])
    begin
      host.xfer(1'b0, a[i], 32'h0, rd);
      chk(rd, 32'h0);
    end
    host.xfer(1'b0, 8'h40, 32'h0, rd);
    chk({31'h0, host.err}, 32'h1);
    host.xfer(1'b1, OFS_OUTPUT_SUM_SIGN, 32'hFFFF_FFFF, rd);
    host.xfer(1'b0, OFS_OUTPUT_SUM_SIGN, 32'h0, rd);
    chk(rd, 32'h0);
    for (int i = 4; i < 10; i += 5)
    begin
      host.xfer(1'b1, a[i], 32'hAB80_0001, rd);
      host.xfer(1'b0, a[i], 32'h0, rd);
      chk(rd, 32'h0F80_0001);
    end
    $display("test regs done");
  endtask

  task automatic t_accum();
    host.xfer(1'b1, OFS_ACCUM_MODE_CONFIG, 32'h0, rd);
    samp('{100, -30, 20}, '{5, 7, -3}, '{50, 50, 50});
    chk(32'(path1_power_sum), 32'(90));
    chk(32'(path2_power_sum), 32'(9));
    chk(32'(path3_power_sum), 32'(9));
    host.xfer(1'b1, OFS_ACCUM_MODE_CONFIG, 32'h0000_000B, rd);
    samp('{100, -30, 20}, '{5, 7, -3}, '{50, 50, 50});
    chk(32'(path1_power_sum), 32'(150));
    chk(32'(path2_power_sum), 32'(-5));
    chk(32'(path3_power_sum), 32'(-5));
    $display("test accum done");
  endtask

  task automatic t_sign();
    int fb [3] = '{BIT_PATH1_SIGN_CHANGE, BIT_PATH2_SIGN_CHANGE, BIT_PATH3_SIGN_CHANGE};
    int sb [3] = '{BIT_PATH1_SUM_SIGN, BIT_PATH2_SUM_SIGN, BIT_PATH3_SUM_SIGN};
    for (int i = 0; i < 3; i++)
    begin
      host.xfer(1'b1, OFS_INT_MASK_FIRST, 32'h1 << fb[i], rd);
      pulse(i, 1'b1);
      chk({31'h0, first_interrupt_pin_n}, 32'h0);
      host.service(OFS_INT_STATUS_FIRST, OFS_OUTPUT_SUM_SIGN, st, ph);
      chk(st, 32'h1 << fb[i]);
      chk({31'h0, ph[sb[i]]}, 32'h1);
      repeat (4) @(posedge clk);
      chk({31'h0, first_interrupt_pin_n}, 32'h1);
      pulse(i, 1'b1);
      host.xfer(1'b0, OFS_INT_STATUS_FIRST, 32'h0, rd);
      chk(rd, 32'h0);
      pulse(i, 1'b0);
      host.service(OFS_INT_STATUS_FIRST, OFS_OUTPUT_SUM_SIGN, st, ph);
      chk({31'h0, ph[sb[i]]}, 32'h0);
      chk(st, 32'h1 << fb[i]);
    end
    $display("test sign done");
  endtask

  task automatic t_noload();
    host.xfer(1'b1, OFS_ACTIVE_NL_THR, 32'hA, rd);
    host.xfer(1'b1, OFS_REACTIVE_NL_THR, 32'hA, rd);
    host.xfer(1'b1, OFS_APPARENT_NL_THR, 32'hA, rd);
    host.xfer(1'b1, OFS_INT_MASK_SECOND, 32'h5, rd);
    path3_type_select <= SEL_APPARENT;
    samp('{-10, 0, 500}, '{10, 11, 500}, '{-10, 100, 500});
    chk({31'h0, second_interrupt_pin_n}, 32'h0);
    chk(32'(path1_power_sum), 32'(500));
    chk(32'(path2_power_sum), 32'(511));
    chk(32'(path3_power_sum), 32'(600));
    host.service(OFS_INT_STATUS_SECOND, OFS_NOLOAD_PHASE_STATE, st, ph);
    chk(st, 32'h5);
    chk(ph, 32'h41);
    samp('{-10, 0, 500}, '{10, 11, 500}, '{-10, 100, 500});
    host.xfer(1'b0, OFS_INT_STATUS_SECOND, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, second_interrupt_pin_n}, 32'h1);
    host.xfer(1'b1, OFS_ACTIVE_NL_THR, 32'h00FF_FFFF, rd);
    host.xfer(1'b1, OFS_APPARENT_NL_THR, 32'h0080_0000, rd);
    samp('{-10, 0, 500}, '{10, 11, 500}, '{-10, 100, 500});
    chk(32'(path1_power_sum), 32'(510));
    chk(32'(path3_power_sum), 32'(590));
    host.service(OFS_INT_STATUS_SECOND, OFS_NOLOAD_PHASE_STATE, st, ph);
    chk(st, 32'h5);
    chk(ph, 32'h0);
    $display("test noload done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // reset, then the scenarios
  initial
  begin
    ap = '{0, 0, 0};
    rp = '{0, 0, 0};
    sp = '{0, 0, 0};
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_accum();
    t_sign();
    t_noload();
    finish_test();
  end
endmodule
